// ---- pkg/rst_seq_pkg.sv ----
// constants and types of the reset cause and start-up sequencer
// Behaviour
// - either detector trip clears brown-out flag, except a mode 10 low-power trip
// - low-power trip ORed into combined brown-out
// - low-power detector enable is active low
// - mode 10 low-power trip holds reset, rearms power-on
// - pin reset disabled only if both bits zero
// - enabled pin held low keeps device reset
// - pin filter ignores short pulses, never driven
// - disabled pin is input with software pull-up
// - watchdog expiry resets, clears watchdog, timeout flags
// - reset instruction clears its own flag
// - stack faults reset only when enabled, set flag
// - power-up timer 64 ms, holds reset
// - run after timer, pin, oscillator done
// - timers independent of pin; 10 cycles after pin
// - reset loads address zero; wake continues next
// - interrupt wake with irq enable vectors to 0004h
// - power-on loads its flag pattern, keeps brown-out flag
// - brown-out loads its pattern; others own flags
// - pin reset clears flag; in sleep timeout, powerdown
// - watchdog wake clears both; interrupt wake sets timeout
// - soft enable acts only in mode 01
// - ready bit shows detector active; bit 6 zero
// - mode encodings 11 on, 10 sleep off, 01, 00
// - flags change only on cause; writes never reset (register writes also change cause and status flags)
package rst_seq_pkg;
   localparam logic [3:0] addr_brownout_control = 4'h0;
   localparam logic [3:0] addr_reset_cause = 4'h4;
   localparam logic [3:0] addr_status = 4'h8;
   localparam logic [3:0] addr_pin_ctrl = 4'hc;
   localparam int bit_soft_bo = 7;
   localparam int bit_reserved6 = 6;
   localparam int bit_bo_ready = 0;
   localparam int bit_stk_ovf = 7;
   localparam int bit_stk_unf = 6;
   localparam int bit_wdt = 4;
   localparam int bit_pin = 3;
   localparam int bit_instr = 2;
   localparam int bit_por = 1;
   localparam int bit_bor = 0;
   localparam int bit_timeout = 1;
   localparam int bit_powerdown = 0;
   localparam logic [7:0] cause_mask = 8'hdf;
   localparam logic [7:0] por_cause = 8'h1c;
   localparam logic [7:0] soft_bo_reset = 8'h80;
   localparam logic [1:0] mode_always_on = 2'b11;
   localparam logic [1:0] mode_sleep_off = 2'b10;
   localparam logic [1:0] mode_software = 2'b01;
   localparam logic [1:0] mode_always_off = 2'b00;
   localparam logic [15:0] reset_vector = 16'h0000;
   localparam logic [15:0] irq_vector = 16'h0004;
   localparam int clk_mhz = 200;
   localparam int lf_khz = 31;
   localparam int lf_div = (clk_mhz * 1000 + lf_khz - 1) / lf_khz;
   localparam int power_up_timer_ms = 64;
   localparam int power_up_timer_ticks = power_up_timer_ms * lf_khz;
   localparam int pin_release_cycles = 10;
   localparam int pin_filter_len = 4;
   typedef enum logic [2:0] {
      st_por, st_power_up_timer, st_wait_pin, st_wait_osc, st_release, st_run
   } seq_state_t;
endpackage

// ---- rtl/pin_filter.sv ----
// two-stage synchroniser and low-sample pulse filter for the reset pin
`timescale 1ns/10ps
module pin_filter (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin_in,
   input wire logic [3:0] filter_len,
   output logic pin_low
);
   logic sync1_ff;
   logic sync2_ff;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic low_ff;
   logic nxt_low;
   // first stage only feeds the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
      end else begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
      end
   end
   // pin must read low for filter_len samples in a row before reset
   assign nxt_cnt = sync2_ff ? 4'h0 :
                    (cnt_ff == filter_len) ? cnt_ff : cnt_ff + 4'h1;
   assign nxt_low = (filter_len == 4'h0) ? !sync2_ff :
                    (!sync2_ff && nxt_cnt == filter_len);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= 4'h0;
         low_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         low_ff <= nxt_low;
      end
   end
   assign pin_low = low_ff;
endmodule

// ---- rtl/reset_cause_and_startup_sequencer.sv ----
// reset merging, start-up sequence, cause flags and axi4-lite registers
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module reset_cause_and_startup_sequencer #(
   parameter int power_up_timer_ticks = rst_seq_pkg::power_up_timer_ticks,
   parameter int lf_div = rst_seq_pkg::lf_div
) (
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // configuration word bits
   input wire logic [1:0] brownout_mode_select,
   input wire logic low_power_brownout_detector_en_n,
   input wire logic ext_reset_pin_enable,
   input wire logic low_voltage_program_enable,
   input wire logic stack_fault_reset_enable,
   input wire logic power_up_timer_enable_n,
   input wire logic osc_startup_needed,
   // supply monitors and events
   input wire logic por_active,
   input wire logic brownout_trip,
   input wire logic lp_brownout_trip,
   input wire logic brownout_circuit_ready,
   input wire logic osc_startup_done,
   input wire logic master_clear_pin_in,
   input wire logic watchdog_timeout,
   input wire logic reset_instruction,
   input wire logic stack_overflow,
   input wire logic stack_underflow,
   input wire logic prog_mode_exit,
   input wire logic sleeping,
   input wire logic wake_watchdog,
   input wire logic wake_irq,
   input wire logic global_irq_enable,
   input wire logic [15:0] pc_current,
   // outputs
   output logic device_reset,
   output logic brownout_enable,
   output logic pin_gpio_value,
   output logic pin_pullup_en,
   output logic pc_load,
   output logic [15:0] pc_value,
   output logic irq_push
);
   logic [7:0] cause_ff, nxt_cause;
   logic [1:0] stat_ff, nxt_stat;
   logic soft_bo_ff;
   logic pullup_sw_ff;
   rst_seq_pkg::seq_state_t state_ff, nxt_state;
   logic [31:0] lf_cnt_ff;
   logic lf_tick_ff;
   logic [31:0] power_up_timer_cnt_ff;
   logic [3:0] rel_cnt_ff;
   logic rst_ff, bo_en_ff, gpio_ff, pu_ff, pcl_ff, push_ff;
   logic [15:0] pcv_ff;
   logic pin_low;
   logic aw_ok_ff, w_ok_ff, bvalid_ff, rvalid_ff;
   logic [3:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff, bresp_ff;

   // pin function and filter
   wire pin_en = ext_reset_pin_enable | low_voltage_program_enable;
   pin_filter u_filter (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(master_clear_pin_in),
      .filter_len(4'(rst_seq_pkg::pin_filter_len)),
      .pin_low(pin_low)
   );
   wire pin_reset = pin_en & pin_low;

   // brown-out path
   wire lp_en = !low_power_brownout_detector_en_n;
   wire mode_on = (brownout_mode_select == rst_seq_pkg::mode_always_on) |
                  (brownout_mode_select == rst_seq_pkg::mode_sleep_off &&
                   !sleeping) |
                  (brownout_mode_select == rst_seq_pkg::mode_software &&
                   soft_bo_ff);
   wire lp_trip = lp_en & lp_brownout_trip;
   wire bo_combined = (mode_on & brownout_trip) | lp_trip;
   // in mode 10 a low-power trip also rearms the power-on path
   wire por_rearm = lp_trip &&
      brownout_mode_select == rst_seq_pkg::mode_sleep_off;
   wire por_ev = por_active | por_rearm;

   // other reset sources
   wire stk_ovf_rst = stack_overflow & stack_fault_reset_enable;
   wire stk_unf_rst = stack_underflow & stack_fault_reset_enable;
   wire any_soft_rst = watchdog_timeout | reset_instruction | stk_ovf_rst |
                       stk_unf_rst | prog_mode_exit | pin_reset;

   // axi write decode
   wire aw_take = s_axi_awvalid & !aw_ok_ff & !bvalid_ff;
   wire w_take = s_axi_wvalid & !w_ok_ff & !bvalid_ff;
   wire wr_go = aw_ok_ff & w_ok_ff & !bvalid_ff;
   logic [3:0] wstrb_ff;
   wire wstrb_ok = wstrb_ff[0];
   wire wr_lane0 = wr_go & wstrb_ok;
   wire wr_bo = wr_lane0 & awaddr_ff == rst_seq_pkg::addr_brownout_control;
   wire wr_cause = wr_lane0 & awaddr_ff == rst_seq_pkg::addr_reset_cause;
   wire wr_stat = wr_lane0 & awaddr_ff == rst_seq_pkg::addr_status;
   wire wr_pin = wr_lane0 & awaddr_ff == rst_seq_pkg::addr_pin_ctrl;
   wire aw_map = awaddr_ff == rst_seq_pkg::addr_brownout_control |
                 awaddr_ff == rst_seq_pkg::addr_reset_cause |
                 awaddr_ff == rst_seq_pkg::addr_status |
                 awaddr_ff == rst_seq_pkg::addr_pin_ctrl;

   // cause flags: hardware events win over a software write the same cycle
   always_comb begin
      nxt_cause = cause_ff;
      nxt_stat = stat_ff;
      if (wr_cause)
         nxt_cause = wdata_ff[7:0] & rst_seq_pkg::cause_mask;
      if (wr_stat)
         nxt_stat = wdata_ff[1:0];
      if (por_ev) begin
         nxt_cause = rst_seq_pkg::por_cause | {7'h0, cause_ff[0]};
         nxt_stat = 2'b11;
      end else if (bo_combined) begin
         nxt_cause[rst_seq_pkg::bit_stk_ovf] = 1'b0;
         nxt_cause[rst_seq_pkg::bit_stk_unf] = 1'b0;
         nxt_cause[rst_seq_pkg::bit_wdt] = 1'b1;
         nxt_cause[rst_seq_pkg::bit_pin] = 1'b1;
         nxt_cause[rst_seq_pkg::bit_instr] = 1'b1;
         nxt_cause[rst_seq_pkg::bit_bor] = 1'b0;
         nxt_stat = 2'b11;
      end else begin
         if (watchdog_timeout) begin
            nxt_cause[rst_seq_pkg::bit_wdt] = 1'b0;
            nxt_stat[rst_seq_pkg::bit_timeout] = 1'b0;
         end
         if (pin_reset && state_ff == rst_seq_pkg::st_run) begin
            nxt_cause[rst_seq_pkg::bit_pin] = 1'b0;
            if (sleeping)
               nxt_stat = 2'b10;
         end
         if (reset_instruction)
            nxt_cause[rst_seq_pkg::bit_instr] = 1'b0;
         if (stk_ovf_rst)
            nxt_cause[rst_seq_pkg::bit_stk_ovf] = 1'b1;
         if (stk_unf_rst)
            nxt_cause[rst_seq_pkg::bit_stk_unf] = 1'b1;
         if (sleeping && wake_watchdog)
            nxt_stat = 2'b00;
         else if (sleeping && wake_irq)
            nxt_stat = 2'b10;
      end
   end

   // low-frequency tick divider feeding the power-up timer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lf_cnt_ff <= 32'h0;
         lf_tick_ff <= 1'b0;
      end else begin
         lf_tick_ff <= (lf_cnt_ff == 32'(lf_div - 1));
         lf_cnt_ff <= (lf_cnt_ff == 32'(lf_div - 1)) ? 32'h0 :
                      lf_cnt_ff + 32'h1;
      end
   end

   wire power_up_timer_done = power_up_timer_enable_n |
                    (power_up_timer_cnt_ff == 32'(power_up_timer_ticks));
   wire osc_ok = !osc_startup_needed | osc_startup_done;

   // start-up sequence
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         rst_seq_pkg::st_por:
            if (!por_ev && !bo_combined)
               nxt_state = rst_seq_pkg::st_power_up_timer;
         rst_seq_pkg::st_power_up_timer:
            if (power_up_timer_done)
               nxt_state = rst_seq_pkg::st_wait_pin;
         rst_seq_pkg::st_wait_pin:
            if (!pin_reset)
               nxt_state = rst_seq_pkg::st_wait_osc;
         rst_seq_pkg::st_wait_osc:
            if (osc_ok)
               nxt_state = rst_seq_pkg::st_release;
         rst_seq_pkg::st_release:
            if (pin_reset)
               nxt_state = rst_seq_pkg::st_wait_pin;
            else if (rel_cnt_ff == 4'(rst_seq_pkg::pin_release_cycles - 1))
               nxt_state = rst_seq_pkg::st_run;
         rst_seq_pkg::st_run:
            if (any_soft_rst)
               nxt_state = rst_seq_pkg::st_wait_pin;
         default:
            nxt_state = rst_seq_pkg::st_por;
      endcase
      if (por_ev || bo_combined)
         nxt_state = rst_seq_pkg::st_por;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= rst_seq_pkg::st_por;
         power_up_timer_cnt_ff <= 32'h0;
         rel_cnt_ff <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         // timer runs regardless of the pin, restarts on supply reset
         if (state_ff == rst_seq_pkg::st_por)
            power_up_timer_cnt_ff <= 32'h0;
         else if (lf_tick_ff && !power_up_timer_done)
            power_up_timer_cnt_ff <= power_up_timer_cnt_ff + 32'h1;
         rel_cnt_ff <= (state_ff == rst_seq_pkg::st_release) ?
                       rel_cnt_ff + 4'h1 : 4'h0;
      end
   end

   // registers and outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cause_ff <= rst_seq_pkg::por_cause;
         stat_ff <= 2'b11;
         soft_bo_ff <= rst_seq_pkg::soft_bo_reset[rst_seq_pkg::bit_soft_bo];
         pullup_sw_ff <= 1'b0;
      end else begin
         cause_ff <= nxt_cause;
         stat_ff <= nxt_stat;
         if (wr_bo)
            soft_bo_ff <= wdata_ff[rst_seq_pkg::bit_soft_bo];
         if (wr_pin)
            pullup_sw_ff <= wdata_ff[0];
      end
   end

   wire run_start = state_ff == rst_seq_pkg::st_release &&
                    nxt_state == rst_seq_pkg::st_run;
   wire wake = sleeping & (wake_watchdog | wake_irq) &
               state_ff == rst_seq_pkg::st_run;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_ff <= 1'b1;
         bo_en_ff <= 1'b0;
         gpio_ff <= 1'b1;
         pu_ff <= 1'b1;
         pcl_ff <= 1'b0;
         pcv_ff <= rst_seq_pkg::reset_vector;
         push_ff <= 1'b0;
      end else begin
         rst_ff <= nxt_state != rst_seq_pkg::st_run;
         bo_en_ff <= mode_on;
         gpio_ff <= master_clear_pin_in;
         pu_ff <= pin_en | pullup_sw_ff;
         pcl_ff <= run_start | wake;
         push_ff <= wake & wake_irq & global_irq_enable;
         if (run_start)
            pcv_ff <= rst_seq_pkg::reset_vector;
         else if (wake && wake_irq && global_irq_enable)
            pcv_ff <= rst_seq_pkg::irq_vector;
         else if (wake)
            pcv_ff <= pc_current + 16'h1;
      end
   end

   // axi4-lite slave: one write and one read outstanding
   wire rd_map = s_axi_araddr == rst_seq_pkg::addr_brownout_control |
                 s_axi_araddr == rst_seq_pkg::addr_reset_cause |
                 s_axi_araddr == rst_seq_pkg::addr_status |
                 s_axi_araddr == rst_seq_pkg::addr_pin_ctrl;
   wire [31:0] bo_word = {24'h0, soft_bo_ff, 1'b0, 5'h0,
                          brownout_circuit_ready & mode_on};
   wire [31:0] rd_word =
      (s_axi_araddr == rst_seq_pkg::addr_brownout_control) ? bo_word :
      (s_axi_araddr == rst_seq_pkg::addr_reset_cause) ? {24'h0, cause_ff} :
      (s_axi_araddr == rst_seq_pkg::addr_status) ? {30'h0, stat_ff} :
      (s_axi_araddr == rst_seq_pkg::addr_pin_ctrl) ?
         {30'h0, gpio_ff, pullup_sw_ff} : 32'h0;
   wire ar_take = s_axi_arvalid & !rvalid_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_ff <= 1'b0;
         w_ok_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= 2'b00;
         awaddr_ff <= 4'h0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= 2'b00;
      end else begin
         if (aw_take) begin
            aw_ok_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (w_take) begin
            w_ok_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= aw_map ? 2'b00 : 2'b10;
         end else if (bvalid_ff && s_axi_bready)
            bvalid_ff <= 1'b0;
         if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_map ? 2'b00 : 2'b10;
         end else if (rvalid_ff && s_axi_rready)
            rvalid_ff <= 1'b0;
      end
   end

   // readies are registered-free combinational of state flops only
   assign s_axi_awready = !aw_ok_ff & !bvalid_ff;
   assign s_axi_wready = !w_ok_ff & !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign device_reset = rst_ff;
   assign brownout_enable = bo_en_ff;
   assign pin_gpio_value = gpio_ff;
   assign pin_pullup_en = pu_ff;
   assign pc_load = pcl_ff;
   assign pc_value = pcv_ff;
   assign irq_push = push_ff;
endmodule

// ---- test/rst_seq_sva.sv ----
// assertion checker for the reset cause and start-up sequencer
`timescale 1ns/10ps
module rst_seq_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] brownout_mode_select,
   input wire logic ext_reset_pin_enable,
   input wire logic low_voltage_program_enable,
   input wire logic por_active,
   input wire logic master_clear_pin_in,
   input wire logic device_reset,
   input wire logic brownout_enable,
   input wire logic pin_gpio_value,
   input wire logic pin_pullup_en,
   input wire logic pc_load,
   input wire logic [15:0] pc_value
);
   wire pin_en = ext_reset_pin_enable | low_voltage_program_enable;
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_por_hold;
      por_active |-> ##[1:2] device_reset;
   endproperty
   a_por_hold: assert property (p_por_hold)
      else $error("power-on did not hold the device in reset");
   property p_pin_hold;
      (pin_en && !master_clear_pin_in) [*8] |-> device_reset;
   endproperty
   a_pin_hold: assert property (p_pin_hold)
      else $error("low reset pin did not hold the device in reset");
   property p_gpio;
      !pin_en |=> pin_gpio_value == $past(master_clear_pin_in);
   endproperty
   a_gpio: assert property (p_gpio)
      else $error("pin level not passed to general input");
   property p_pullup;
      pin_en [*2] |-> pin_pullup_en;
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("pull-up off while reset pin enabled");
   property p_mode_off;
      (brownout_mode_select == 2'h0) [*2] |-> !brownout_enable;
   endproperty
   a_mode_off: assert property (p_mode_off)
      else $error("detector on in always-off mode");
   property p_mode_on;
      (brownout_mode_select == 2'h3) [*2] |-> brownout_enable;
   endproperty
   a_mode_on: assert property (p_mode_on)
      else $error("detector off in always-on mode");
   property p_start_vec;
      $fell(device_reset) |-> ##[0:1] (pc_load && pc_value == 16'h0000);
   endproperty
   a_start_vec: assert property (p_start_vec)
      else $error("start after reset not at address zero");
   property p_run_delay;
      pin_en && device_reset && $rose(master_clear_pin_in)
         |=> device_reset [*8];
   endproperty
   a_run_delay: assert property (p_run_delay)
      else $error("execution began too soon after pin release");
endmodule
bind reset_cause_and_startup_sequencer rst_seq_sva chk_i (
   .aclk, .aresetn, .brownout_mode_select, .ext_reset_pin_enable,
   .low_voltage_program_enable, .por_active, .master_clear_pin_in,
   .device_reset, .brownout_enable, .pin_gpio_value, .pin_pullup_en,
   .pc_load, .pc_value);

// ---- test/rst_supply_model.sv ----
// behavioural supply monitors and reset pin driver facing the sequencer
`timescale 1ns/10ps
module rst_supply_model #(
   parameter int por_cycles = 8,
   parameter int osc_cycles = 6
) (
   input wire logic aclk,
   input wire logic supply_low,
   input wire logic lp_low,
   input wire logic pin_low,
   output logic por_active,
   output logic brownout_trip,
   output logic lp_brownout_trip,
   output logic brownout_circuit_ready,
   output logic osc_startup_done,
   output logic master_clear_pin_in
);
   int t = 0;
   int osc_cnt = 0;
   always @(posedge aclk) begin
      t <= t + 1;
      osc_cnt <= (por_active || brownout_trip) ? 0 : osc_cnt + 1;
   end
   assign por_active = t < por_cycles;
   assign brownout_trip = supply_low;
   assign lp_brownout_trip = lp_low;
   // the detector needs a settling spell after power-on
   assign brownout_circuit_ready = t >= por_cycles + 2;
   assign osc_startup_done = osc_cnt >= osc_cycles;
   // released pin is only pulled up, never driven high
   assign master_clear_pin_in = pin_low ? 1'h0 : 1'h1;
endmodule

// ---- test/reset_cause_and_startup_sequencer_tb.sv ----
// self-checking bench for the reset cause and start-up sequencer
`timescale 1ns/10ps
module reset_cause_and_startup_sequencer_tb;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
   logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
   logic [1:0] brownout_mode_select = 2'h3;
   logic low_power_brownout_detector_en_n = 1'h1;
   logic ext_reset_pin_enable = 1'h1, low_voltage_program_enable = 1'h0;
   logic stack_fault_reset_enable = 1'h0, power_up_timer_enable_n = 1'h0;
   logic osc_startup_needed = 1'h1, sleeping = 1'h0, global_irq_enable = 1'h0;
   logic [15:0] pc_current = 16'h0123;
   logic [6:0] ev = 7'h0;
   logic supply_low = 1'h0, lp_low = 1'h0, pin_low = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, por_active, brownout_trip, lp_brownout_trip;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic brownout_circuit_ready, osc_startup_done, master_clear_pin_in;
   logic device_reset, brownout_enable, pin_gpio_value, pin_pullup_en;
   logic pc_load, irq_push;
   logic [15:0] pc_value;
   int n_mismatch = 0, checks = 0, n;
   always #2.5 aclk = ~aclk;
   reset_cause_and_startup_sequencer #(.power_up_timer_ticks(4), .lf_div(2)) uut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .brownout_mode_select, .low_power_brownout_detector_en_n,
      .ext_reset_pin_enable, .low_voltage_program_enable,
      .stack_fault_reset_enable, .power_up_timer_enable_n, .osc_startup_needed,
      .por_active, .brownout_trip, .lp_brownout_trip, .brownout_circuit_ready,
      .osc_startup_done, .master_clear_pin_in, .watchdog_timeout(ev[0]),
      .reset_instruction(ev[1]), .stack_overflow(ev[2]),
      .stack_underflow(ev[3]), .prog_mode_exit(ev[4]), .sleeping,
      .wake_watchdog(ev[5]), .wake_irq(ev[6]), .global_irq_enable,
      .pc_current, .device_reset, .brownout_enable, .pin_gpio_value,
      .pin_pullup_en, .pc_load, .pc_value, .irq_push);
   rst_supply_model model (.aclk, .supply_low, .lp_low, .pin_low, .por_active,
      .brownout_trip, .lp_brownout_trip, .brownout_circuit_ready,
      .osc_startup_done, .master_clear_pin_in);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      chk(s_axi_rdata, e);
   endtask
   task automatic pulse(input int i);
      ev[i] <= 1'h1;
      @(posedge aclk);
      ev[i] <= 1'h0;
   endtask
   task automatic spike(input logic sup);
      if (sup) supply_low <= 1'h1;
      else lp_low <= 1'h1;
      repeat (4) @(posedge aclk);
      supply_low <= 1'h0;
      lp_low <= 1'h0;
   endtask
   // a reset that never clears must not hang the wait for release
   task automatic rst_seen(input logic e);
      logic s;
      int k;
      s = 1'h0;
      k = 0;
      repeat (6) begin
         @(posedge aclk);
         if (device_reset === 1'h1) s = 1'h1;
      end
      chk({31'h0, s}, {31'h0, e});
      while (device_reset !== 1'h0 && k < 400) begin
         @(posedge aclk);
         k++;
      end
      chk({31'h0, device_reset}, 32'h0);
   endtask
   task automatic watch(input logic [2:0] e, input logic [2:0] m);
      logic [2:0] s;
      s = 3'h0;
      repeat (8) begin
         @(posedge aclk);
         s[0] = s[0] | (pc_load === 1'h1 && pc_value === 16'h0124);
         s[1] = s[1] | (pc_load === 1'h1 && pc_value === 16'h0004);
         s[2] = s[2] | (irq_push === 1'h1);
      end
      chk({29'h0, s & m}, {29'h0, e});
   endtask
   task automatic tally_and_finish();
      if (n_mismatch == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rst_seen(1'h1);
      rd(4'h4, 32'h1c, 2'h0);
      rd(4'h8, 32'h3, 2'h0);
      rd(4'h0, 32'h81, 2'h0);
      wr(4'h6, 32'hff, 2'h2);
      wr(4'h4, 32'hff, 2'h0);
      rst_seen(1'h0);
      rd(4'h4, 32'hdf, 2'h0);
      wr(4'h4, 32'h1f, 2'h0);
      pulse(1);
      rst_seen(1'h1);
      rd(4'h4, 32'h1b, 2'h0);
      pulse(0);
      rst_seen(1'h1);
      rd(4'h4, 32'h0b, 2'h0);
      rd(4'h8, 32'h1, 2'h0);
      pulse(2);
      rst_seen(1'h0);
      stack_fault_reset_enable <= 1'h1;
      pulse(2);
      rst_seen(1'h1);
      pulse(3);
      rst_seen(1'h1);
      rd(4'h4, 32'hcb, 2'h0);
      pin_low <= 1'h1;
      repeat (3) @(posedge aclk);
      pin_low <= 1'h0;
      rst_seen(1'h0);
      ext_reset_pin_enable <= 1'h0;
      pin_low <= 1'h1;
      wr(4'hc, 32'h0, 2'h0);
      rd(4'hc, 32'h0, 2'h0);
      chk({31'h0, pin_pullup_en}, 32'h0);
      wr(4'hc, 32'h1, 2'h0);
      rd(4'hc, 32'h1, 2'h0);
      chk({31'h0, pin_pullup_en}, 32'h1);
      for (int i = 0; i < 4; i++) begin
         {ext_reset_pin_enable, low_voltage_program_enable} <= i[1:0];
         @(posedge aclk);
         pin_low <= 1'h1;
         repeat (12) @(posedge aclk);
         chk({31'h0, device_reset}, {31'h0, i != 0});
         pin_low <= 1'h0;
         n = 0;
         @(posedge aclk);
         while (device_reset === 1'h1 && n < 50) begin
            @(posedge aclk);
            n++;
         end
         if (i != 0) chk({31'h0, n >= 9 && n <= 20}, 32'h1);
      end
      rd(4'h4, 32'hc3, 2'h0);
      spike(1'h1);
      rst_seen(1'h1);
      rd(4'h4, 32'h1e, 2'h0);
      rd(4'h8, 32'h3, 2'h0);
      wr(4'h4, 32'h1f, 2'h0);
      spike(1'h0);
      rst_seen(1'h0);
      low_power_brownout_detector_en_n <= 1'h0;
      spike(1'h0);
      rst_seen(1'h1);
      rd(4'h4, 32'h1e, 2'h0);
      brownout_mode_select <= 2'h2;
      spike(1'h0);
      rst_seen(1'h1);
      rd(4'h4, 32'h1c, 2'h0);
      wr(4'h0, 32'h80, 2'h0);
      for (int m = 0; m < 4; m++) begin
         brownout_mode_select <= m[1:0];
         repeat (3) @(posedge aclk);
         chk({31'h0, brownout_enable}, {31'h0, m != 0});
      end
      brownout_mode_select <= 2'h1;
      wr(4'h0, 32'h0, 2'h0);
      rd(4'h0, 32'h0, 2'h0);
      chk({31'h0, brownout_enable}, 32'h0);
      wr(4'h0, 32'hc0, 2'h0);
      rd(4'h0, 32'h81, 2'h0);
      brownout_mode_select <= 2'h0;
      rd(4'h0, 32'h80, 2'h0);
      pulse(4);
      rst_seen(1'h1);
      brownout_mode_select <= 2'h2;
      sleeping <= 1'h1;
      repeat (3) @(posedge aclk);
      chk({31'h0, brownout_enable}, 32'h0);
      pulse(5);
      watch(3'h1, 3'h7);
      rd(4'h8, 32'h0, 2'h0);
      global_irq_enable <= 1'h1;
      pulse(6);
      watch(3'h6, 3'h6);
      rd(4'h8, 32'h2, 2'h0);
      s_axi_wstrb <= 4'h0;
      wr(4'h8, 32'h3, 2'h0);
      rd(4'h8, 32'h2, 2'h0);
      tally_and_finish();
   end
endmodule
